// ===== rtl/vic_top.sv
// vectored and fast interrupt controller of the 8-bit core
`timescale 1ns/100ps
module vic_top
#(
    parameter int NUM_SRC = 16,
    parameter int SRC_PER_LEVEL = 2
)
(
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic [NUM_SRC-1:0] i_src_pend,
    input wire logic [NUM_SRC-1:0] i_src_en,
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_rd,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_hit,
    input wire logic i_instr_end,
    input wire logic i_ei,
    input wire logic i_di,
    input wire logic i_interrupt_return_instr,
    input wire logic [15:0] i_pc,
    input wire logic [7:0] i_flags,
    output logic o_int_ack,
    output vic_pkg::vic_level_t o_ack_level,
    output logic o_busy,
    output logic o_push,
    output logic [7:0] o_push_data,
    output logic o_vec_rd,
    output logic [7:0] o_vec_addr,
    input wire logic [7:0] i_vec_data,
    output logic o_pc_load,
    output logic [15:0] o_pc_value,
    output logic o_flags_load,
    output logic [7:0] o_flags_value,
    output logic o_fast_status,
    output logic o_global_en
);
    import vic_pkg::*;

    vic_rslv_if rsl ();
    vic_level_resolver u_rslv (.rs(rsl.rslv));

    vic_state_e state;
    logic [7:0] level_request_status;
    logic [7:0] level_mask_reg;
    logic [7:0] level_priority_reg;
    logic [15:0] fast_handler_pointer;
    logic fast_enable_bit;
    vic_level_t fast_level_select;
    logic [7:0] shadow_flags;
    logic [7:0] vec_ptr;
    logic [7:0] vec_hi;
    logic [4:0] cnt;
    logic entry_fast;
    logic [7:0] lvl_raw;
    logic [7:0] next_vec;
    logic take, take_fast, fast_ret, sw_wr;

    // ==========================================
    // level requests from peripheral pending flags
    // pending flags live in the peripherals and are only cleared by their
    // handlers, so nothing here ever clears one
    always_comb
    begin
        lvl_raw = 8'h00;
        for (int s = 0; s < NUM_SRC; s++)
            lvl_raw[s / SRC_PER_LEVEL] |= i_src_pend[s] & i_src_en[s];
    end

    // status register follows requests even while globally disabled
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
            level_request_status <= LRS_RESET;
        else
            level_request_status <= lvl_raw;
    end

    // masked levels feed the priority tree
    assign rsl.level_req = level_request_status & level_mask_reg;
    assign rsl.prio = level_priority_reg;

    // lowest numbered source of the winning level has the lowest vector
    always_comb
    begin
        next_vec = VEC_BASE;
        for (int s = NUM_SRC - 1; s >= 0; s--)
        begin
            if ((s / SRC_PER_LEVEL) == int'(rsl.level) && i_src_pend[s] && i_src_en[s])
                next_vec = 8'(VEC_BASE + 2 * s);
        end
    end

    // ==========================================
    // acceptance
    // fast entry is refused while a fast routine runs: the pointer then
    // holds the interrupted pc and a second swap would lose it
    assign sw_wr = i_reg_wr && (state == ST_IDLE);
    assign take = (state == ST_IDLE) && i_instr_end && o_global_en && rsl.hit;
    assign take_fast = take && fast_enable_bit && !o_fast_status
        && (rsl.level == fast_level_select);
    assign fast_ret = (state == ST_IDLE) && i_interrupt_return_instr && o_fast_status;

    // ==========================================
    // software visible control registers
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            level_mask_reg <= MASK_RESET;
            level_priority_reg <= PRIO_RESET;
            fast_enable_bit <= 1'b0;
            fast_level_select <= FSEL_RESET;
        end
        else if (sw_wr)
        begin
            if (i_reg_addr == ADDR_MASK)
                level_mask_reg <= i_reg_wdata;
            if (i_reg_addr == ADDR_PRIO)
                level_priority_reg <= i_reg_wdata;
            if (i_reg_addr == ADDR_SYSMODE)
            begin
                fast_enable_bit <= i_reg_wdata[SYM_FEN_BIT];
                fast_level_select <= i_reg_wdata[SYM_FSEL_MSB:SYM_FSEL_LSB];
            end
        end
    end

    // global enable: entry clears, return sets, then instructions, then writes
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
            o_global_en <= 1'b0;
        else if (take)
            o_global_en <= 1'b0;
        else if ((state == ST_IDLE) && i_interrupt_return_instr)
            o_global_en <= 1'b1;
        else if (i_di)
            o_global_en <= 1'b0;
        else if (i_ei)
            o_global_en <= 1'b1;
        else if (sw_wr && (i_reg_addr == ADDR_SYSMODE))
            o_global_en <= i_reg_wdata[SYM_GEN_BIT];
    end

    // fast pointer: hardware swap beats a software write in the same cycle
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
            fast_handler_pointer <= FHP_RESET;
        else if (take_fast || fast_ret)
            fast_handler_pointer <= i_pc;
        else if (sw_wr && (i_reg_addr == ADDR_FHP_HIGH))
            fast_handler_pointer[15:8] <= i_reg_wdata;
        else if (sw_wr && (i_reg_addr == ADDR_FHP_LOW))
            fast_handler_pointer[7:0] <= i_reg_wdata;
    end

    // shadow flags and fast status; shadow has no register address
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            shadow_flags <= 8'h00;
            o_fast_status <= 1'b0;
        end
        else if (take_fast)
        begin
            shadow_flags <= i_flags;
            o_fast_status <= 1'b1;
        end
        else if (fast_ret)
            o_fast_status <= 1'b0;
    end

    // ==========================================
    // register read port, data registered one cycle after the strobe
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            o_reg_rdata <= 8'h00;
            o_reg_hit <= 1'b0;
        end
        else
        begin
            o_reg_hit <= 1'b0;
            o_reg_rdata <= 8'h00;
            if (i_reg_rd)
            begin
                o_reg_hit <= 1'b1;
                unique case (i_reg_addr)
                    ADDR_FHP_HIGH: o_reg_rdata <= fast_handler_pointer[15:8];
                    ADDR_FHP_LOW: o_reg_rdata <= fast_handler_pointer[7:0];
                    ADDR_LRS: o_reg_rdata <= level_request_status;
                    ADDR_MASK: o_reg_rdata <= level_mask_reg;
                    ADDR_PRIO: o_reg_rdata <= level_priority_reg;
                    ADDR_SYSMODE: o_reg_rdata <= {3'h0, fast_level_select,
                        fast_enable_bit, o_global_en};
                    default: o_reg_hit <= 1'b0;
                endcase
            end
        end
    end

    // ==========================================
    // entry sequencer; a cycle counter stretches both entries to their length
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            state <= ST_IDLE;
            cnt <= 5'h00;
            entry_fast <= 1'b0;
            vec_ptr <= VEC_BASE;
            vec_hi <= 8'h00;
            o_int_ack <= 1'b0;
            o_ack_level <= 3'h0;
            o_busy <= 1'b0;
            o_push <= 1'b0;
            o_push_data <= 8'h00;
            o_vec_rd <= 1'b0;
            o_vec_addr <= VEC_BASE;
            o_pc_load <= 1'b0;
            o_pc_value <= 16'h0000;
            o_flags_load <= 1'b0;
            o_flags_value <= 8'h00;
        end
        else
        begin
            o_int_ack <= 1'b0;
            o_push <= 1'b0;
            o_vec_rd <= 1'b0;
            o_pc_load <= 1'b0;
            o_flags_load <= 1'b0;
            cnt <= 5'(cnt + 5'h01);
            unique case (state)
                ST_IDLE:
                begin
                    cnt <= 5'h01;
                    if (take)
                    begin
                        o_int_ack <= 1'b1;
                        o_ack_level <= rsl.level;
                        o_busy <= 1'b1;
                        entry_fast <= take_fast;
                        vec_ptr <= next_vec;
                        if (take_fast)
                        begin
                            o_pc_value <= fast_handler_pointer;
                            state <= ST_WAIT;
                        end
                        else
                        begin
                            o_push <= 1'b1;
                            o_push_data <= i_pc[7:0];
                            o_pc_value <= i_pc;
                            o_flags_value <= i_flags;
                            state <= ST_PUSH_HI;
                        end
                    end
                    else if (fast_ret)
                    begin
                        o_pc_load <= 1'b1;
                        o_pc_value <= fast_handler_pointer;
                        o_flags_load <= 1'b1;
                        o_flags_value <= shadow_flags;
                    end
                end
                ST_PUSH_HI:
                begin
                    o_push <= 1'b1;
                    o_push_data <= o_pc_value[15:8];
                    state <= ST_PUSH_FLG;
                end
                ST_PUSH_FLG:
                begin
                    o_push <= 1'b1;
                    o_push_data <= o_flags_value;
                    state <= ST_VEC_HI;
                end
                ST_VEC_HI:
                begin
                    o_vec_rd <= 1'b1;
                    o_vec_addr <= vec_ptr;
                    state <= ST_VEC_LO;
                end
                ST_VEC_LO:
                begin
                    o_vec_rd <= 1'b1;
                    o_vec_addr <= 8'(vec_ptr + 8'h01);
                    state <= ST_CAP_HI;
                end
                ST_CAP_HI:
                begin
                    vec_hi <= i_vec_data;
                    state <= ST_CAP_LO;
                end
                ST_CAP_LO:
                begin
                    o_pc_value <= {vec_hi, i_vec_data};
                    state <= ST_WAIT;
                end
                ST_WAIT:
                begin
                    if (cnt == (entry_fast ? FAST_LAST : NORM_LAST))
                    begin
                        o_pc_load <= 1'b1;
                        o_busy <= 1'b0;
                        state <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ==========================================
    // checks
    chk_lrs_read: assert property (@(posedge i_clock) disable iff (i_rst)
        (i_reg_rd && i_reg_addr == ADDR_LRS) |=> o_reg_rdata == $past(level_request_status))
        else $error("status read does not return status");
    chk_lrs_track: assert property (@(posedge i_clock) disable iff (i_rst)
        ##1 level_request_status == $past(lvl_raw))
        else $error("status does not follow level requests");
    chk_no_take_off: assert property (@(posedge i_clock) disable iff (i_rst)
        !o_global_en |=> !o_int_ack)
        else $error("acknowledge while globally disabled");
    chk_ack_at_end: assert property (@(posedge i_clock) disable iff (i_rst)
        o_int_ack |-> $past(i_instr_end) && $past(state) == ST_IDLE)
        else $error("acknowledge not at instruction end");
    chk_gen_cleared: assert property (@(posedge i_clock) disable iff (i_rst)
        o_int_ack |-> !o_global_en)
        else $error("global enable still set after entry");
    chk_push_order: assert property (@(posedge i_clock) disable iff (i_rst)
        (o_int_ack && !entry_fast) |-> o_push && o_push_data == $past(i_pc[7:0])
        ##1 o_push && o_push_data == $past(i_pc[15:8], 2)
        ##1 o_push && o_push_data == $past(i_flags, 3))
        else $error("push order wrong");
    chk_vec_even: assert property (@(posedge i_clock) disable iff (i_rst)
        $rose(o_vec_rd) |-> !o_vec_addr[0])
        else $error("vector fetch from odd address");
    chk_norm_len: assert property (@(posedge i_clock) disable iff (i_rst)
        (o_int_ack && !entry_fast) |-> !o_pc_load [*8] ##1 !o_pc_load [*7] ##1 o_pc_load)
        else $error("normal entry length wrong");
    chk_fast_len: assert property (@(posedge i_clock) disable iff (i_rst)
        (o_int_ack && entry_fast) |-> !o_pc_load [*5] ##1 o_pc_load && o_fast_status)
        else $error("fast entry length wrong");
    chk_interrupt_return_instr_gen: assert property (@(posedge i_clock) disable iff (i_rst)
        (state == ST_IDLE && i_interrupt_return_instr && !take && !i_di && !i_ei) |=> o_global_en)
        else $error("return did not set global enable");
    chk_fast_ret: assert property (@(posedge i_clock) disable iff (i_rst)
        fast_ret |=> !o_fast_status && o_pc_load && o_flags_load
        && o_flags_value == $past(shadow_flags))
        else $error("fast return did not restore");
endmodule

// ===== rtl/vic_pkg.sv
// constants and types shared by the vectored interrupt controller
package vic_pkg;
    // ==========================================
    // register file locations
    localparam logic [7:0] ADDR_FHP_HIGH = 8'hDA;
    localparam logic [7:0] ADDR_FHP_LOW = 8'hDB;
    localparam logic [7:0] ADDR_LRS = 8'hDC;
    localparam logic [7:0] ADDR_MASK = 8'hDD;
    localparam logic [7:0] ADDR_SYSMODE = 8'hDE;
    localparam logic [7:0] ADDR_PRIO = 8'hFF;
    // ==========================================
    // field positions and reset values
    localparam int SYM_GEN_BIT = 0;
    localparam int SYM_FEN_BIT = 1;
    localparam int SYM_FSEL_LSB = 2;
    localparam int SYM_FSEL_MSB = 4;
    localparam logic [7:0] LRS_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] PRIO_RESET = 8'h00;
    localparam logic [15:0] FHP_RESET = 16'h0000;
    localparam logic [2:0] FSEL_RESET = 3'h0;
    // ==========================================
    // entry timing, in core clocks
    localparam int NORM_ENTRY_CYC = 16;
    localparam int FAST_ENTRY_CYC = 6;
    localparam logic [4:0] NORM_LAST = 5'(NORM_ENTRY_CYC - 1);
    localparam logic [4:0] FAST_LAST = 5'(FAST_ENTRY_CYC - 1);
    // ==========================================
    // vector table in program memory
    localparam logic [7:0] VEC_BASE = 8'h00;
    localparam int NUM_LEVELS = 8;
    typedef logic [2:0] vic_level_t;
    typedef enum {
        ST_IDLE, ST_PUSH_HI, ST_PUSH_FLG, ST_VEC_HI, ST_VEC_LO,
        ST_CAP_HI, ST_CAP_LO, ST_WAIT
    } vic_state_e;
endpackage

// ===== rtl/vic_rslv_if.sv
// carrier between the controller and its level priority resolver
`timescale 1ns/100ps
interface vic_rslv_if;
    logic [7:0] level_req;
    logic [7:0] prio;
    logic hit;
    vic_pkg::vic_level_t level;
    modport ctrl
    (
        output level_req, prio,
        input hit, level
    );
    modport rslv
    (
        input level_req, prio,
        output hit, level
    );
endinterface

// ===== rtl/vic_level_resolver.sv
// picks the highest priority requesting level from the priority setting
`timescale 1ns/100ps
module vic_level_resolver
(
    vic_rslv_if.rslv rs
);
    import vic_pkg::*;

    logic [7:0] r;
    logic [2:0] a_lvl, b_lvl, c_lvl, b34, c67;
    logic a_any, b_any, c_any;
    logic [1:0] ord [3];
    logic [2:0] code;

    // ==========================================
    // winner inside each group
    always_comb
    begin
        r = rs.level_req;
        a_any = r[0] | r[1];
        b_any = r[2] | r[3] | r[4];
        c_any = r[5] | r[6] | r[7];
        if (rs.prio[0])
            a_lvl = r[1] ? 3'h1 : 3'h0;
        else
            a_lvl = r[0] ? 3'h0 : 3'h1;
        if (rs.prio[3])
            b34 = r[4] ? 3'h4 : 3'h3;
        else
            b34 = r[3] ? 3'h3 : 3'h4;
        if (rs.prio[2])
            b_lvl = (r[3] | r[4]) ? b34 : 3'h2;
        else
            b_lvl = r[2] ? 3'h2 : b34;
        if (rs.prio[6])
            c67 = r[7] ? 3'h7 : 3'h6;
        else
            c67 = r[6] ? 3'h6 : 3'h7;
        if (rs.prio[5])
            c_lvl = (r[6] | r[7]) ? c67 : 3'h5;
        else
            c_lvl = r[5] ? 3'h5 : c67;
    end

    // group order from the three group bits, A=0 B=1 C=2
    always_comb
    begin
        code = {rs.prio[7], rs.prio[4], rs.prio[1]};
        unique case (code)
            3'h1: ord = '{2'h1, 2'h2, 2'h0};
            3'h3: ord = '{2'h1, 2'h0, 2'h2};
            3'h4: ord = '{2'h2, 2'h0, 2'h1};
            3'h5: ord = '{2'h2, 2'h1, 2'h0};
            3'h6: ord = '{2'h0, 2'h2, 2'h1};
            default: ord = '{2'h0, 2'h1, 2'h2};
        endcase
    end

    // first group in order that has a request wins
    always_comb
    begin
        rs.hit = a_any | b_any | c_any;
        rs.level = 3'h0;
        for (int i = 2; i >= 0; i--)
        begin
            if ((ord[i] == 2'h0) && a_any)
                rs.level = a_lvl;
            if ((ord[i] == 2'h1) && b_any)
                rs.level = b_lvl;
            if ((ord[i] == 2'h2) && c_any)
                rs.level = c_lvl;
        end
    end
endmodule

// ===== dv/vic_vec_rom_model.sv
// program memory model that answers vector fetches of the controller
`timescale 1ns/100ps
module vic_vec_rom_model
(
    input wire logic i_clock,
    input wire logic i_vec_rd,
    input wire logic [7:0] i_vec_addr,
    output logic [7:0] o_vec_data = 8'h00
);
    // ==========================================
    // vector table
    // whole 00H-FFH area holds entries, so any even start reads a byte pair
    // between fetches the bus toggles so a stale byte never looks valid
    always_ff @(posedge i_clock)
    begin
        if (i_vec_rd)
            o_vec_data <= i_vec_addr ^ 8'hC3;
        else
            o_vec_data <= ~o_vec_data;
    end
endmodule

// ===== dv/test_vic_top.sv
// self-checking testbench for the vectored interrupt controller
`timescale 1ns/100ps
module test_vic_top;
    import vic_pkg::*;
    // ==========================================
    // stimulus and observed signals
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    logic [15:0] i_src_pend = 16'h0000;
    logic [15:0] i_src_en = 16'hFFFF;
    logic [7:0] i_reg_addr = 8'h00;
    logic [7:0] i_reg_wdata = 8'h00;
    logic i_reg_wr = 1'b0;
    logic i_reg_rd = 1'b0;
    logic i_instr_end = 1'b0;
    logic i_ei = 1'b0;
    logic i_di = 1'b0;
    logic i_interrupt_return_instr = 1'b0;
    logic [15:0] i_pc = 16'hABCD;
    logic [7:0] i_flags = 8'h5A;
    logic [7:0] o_reg_rdata, o_push_data, o_vec_addr, i_vec_data, o_flags_value;
    logic [15:0] o_pc_value;
    logic o_reg_hit, o_int_ack, o_busy, o_push, o_vec_rd, o_pc_load, o_flags_load;
    logic o_fast_status, o_global_en;
    vic_level_t o_ack_level;
    int n_mismatch = 0;
    int check_count = 0;
    logic [7:0] pushes[$];
    logic [7:0] prio_tab[8] = '{8'h82, 8'h82, 8'h02, 8'h80, 8'h10, 8'h90, 8'h12, 8'h06};
    logic [15:0] en_tab[8] = '{16'hFBFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFE,
        16'hFFAF, 16'hFFFF};
    logic [2:0] lvl_tab[8] = '{3'h2, 3'h5, 3'h2, 3'h5, 3'h0, 3'h5, 3'h0, 3'h3};

    vic_top vic_top_inst
    (
        .i_clock(i_clock), .i_rst(i_rst), .i_src_pend(i_src_pend), .i_src_en(i_src_en),
        .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata),
        .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .o_reg_hit(o_reg_hit),
        .i_instr_end(i_instr_end), .i_ei(i_ei), .i_di(i_di), .i_interrupt_return_instr(i_interrupt_return_instr),
        .i_pc(i_pc), .i_flags(i_flags), .o_int_ack(o_int_ack), .o_ack_level(o_ack_level),
        .o_busy(o_busy), .o_push(o_push), .o_push_data(o_push_data), .o_vec_rd(o_vec_rd),
        .o_vec_addr(o_vec_addr), .i_vec_data(i_vec_data), .o_pc_load(o_pc_load),
        .o_pc_value(o_pc_value), .o_flags_load(o_flags_load),
        .o_flags_value(o_flags_value), .o_fast_status(o_fast_status),
        .o_global_en(o_global_en)
    );

    vic_vec_rom_model vic_vec_rom_model_inst
    (
        .i_clock(i_clock), .i_vec_rd(o_vec_rd), .i_vec_addr(o_vec_addr),
        .o_vec_data(i_vec_data)
    );

    // ==========================================
    // clock and watchdog
    initial
    begin
        forever #10 i_clock = ~i_clock;
    end

    // the whole run needs well under a thousand cycles
    initial
    begin
        repeat (3000) @(posedge i_clock);
        n_mismatch++;
        tally_and_finish();
    end

    // ==========================================
    // compare tasks
    task automatic chk_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t flag got %b expected %b", $time, got, exp);
        end
    endtask

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t byte got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t word got %h expected %h", $time, got, exp);
        end
    endtask

    // ==========================================
    // register and core access tasks
    task automatic reg_wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge i_clock);
        i_reg_addr <= addr;
        i_reg_wdata <= data;
        i_reg_wr <= 1'b1;
        @(posedge i_clock);
        i_reg_wr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] addr, input logic [7:0] exp, input logic hit);
        @(posedge i_clock);
        i_reg_addr <= addr;
        i_reg_rd <= 1'b1;
        @(posedge i_clock);
        i_reg_rd <= 1'b0;
        #1;
        chk_byte(o_reg_rdata, exp);
        chk_bit(o_reg_hit, hit);
    endtask

    // instruction end with nothing serviceable: no acknowledge may follow
    task automatic no_take;
        @(posedge i_clock);
        i_instr_end <= 1'b1;
        @(posedge i_clock);
        i_instr_end <= 1'b0;
        repeat (3)
        begin
            #1;
            chk_bit(o_int_ack, 1'b0);
            @(posedge i_clock);
        end
    endtask

    // entry sequence: cycle 1 is the acknowledge cycle, pushes are collected
    task automatic take(input logic [2:0] lvl, input logic [15:0] pc_exp, input int ncyc);
        int c;
        pushes.delete();
        @(posedge i_clock);
        i_instr_end <= 1'b1;
        @(posedge i_clock);
        i_instr_end <= 1'b0;
        #1;
        chk_bit(o_int_ack, 1'b1);
        chk_byte({5'h00, o_ack_level}, {5'h00, lvl});
        chk_bit(o_global_en, 1'b0);
        chk_bit(o_busy, 1'b1);
        c = 1;
        while (o_pc_load !== 1'b1 && c < 40)
        begin
            if (o_push === 1'b1)
                pushes.push_back(o_push_data);
            @(posedge i_clock);
            #1;
            c++;
        end
        chk_byte(8'(c), 8'(ncyc));
        chk_bit(o_busy, 1'b0);
        chk_word(o_pc_value, pc_exp);
    endtask

    task automatic interrupt_return_instr;
        @(posedge i_clock);
        i_interrupt_return_instr <= 1'b1;
        @(posedge i_clock);
        i_interrupt_return_instr <= 1'b0;
        #1;
        chk_bit(o_global_en, 1'b1);
    endtask

    // handler address held in the table pair at vector v and v+1
    function automatic logic [15:0] exp_vec(input logic [7:0] v);
        return {v ^ 8'hC3, (v + 8'h01) ^ 8'hC3};
    endfunction

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ==========================================
    // test sequence
    initial
    begin
        repeat (6) @(posedge i_clock);
        i_rst <= 1'b0;
        reg_rd(ADDR_LRS, LRS_RESET, 1'b1);
        reg_rd(ADDR_SYSMODE, 8'h00, 1'b1);
        reg_rd(8'h10, 8'h00, 1'b0);
        @(posedge i_clock);
        i_src_pend <= 16'h0040;
        reg_rd(ADDR_LRS, 8'h08, 1'b1);
        reg_wr(ADDR_LRS, 8'hFF);
        reg_rd(ADDR_LRS, 8'h08, 1'b1);
        no_take();
        @(posedge i_clock);
        i_ei <= 1'b1;
        @(posedge i_clock);
        i_ei <= 1'b0;
        no_take();
        reg_wr(ADDR_MASK, 8'h08);
        take(3'h3, exp_vec(8'h0C), 16);
        chk_byte(pushes[0], 8'hCD);
        chk_byte(pushes[1], 8'hAB);
        chk_byte(pushes[2], 8'h5A);
        chk_byte(8'(pushes.size()), 8'h03);
        // nesting: handler saves the mask, admits level 0 only, re-enables
        reg_rd(ADDR_MASK, 8'h08, 1'b1);
        reg_wr(ADDR_MASK, 8'h01);
        @(posedge i_clock);
        i_ei <= 1'b1;
        i_src_pend <= 16'h0043;
        @(posedge i_clock);
        i_ei <= 1'b0;
        take(3'h0, exp_vec(8'h00), 16);
        @(posedge i_clock);
        i_src_pend <= 16'h0040;
        interrupt_return_instr();
        // outer handler closes: disable, restore the mask, clear, return
        @(posedge i_clock);
        i_di <= 1'b1;
        @(posedge i_clock);
        i_di <= 1'b0;
        #1;
        chk_bit(o_global_en, 1'b0);
        reg_wr(ADDR_MASK, 8'h08);
        @(posedge i_clock);
        i_src_pend <= 16'h0000;
        interrupt_return_instr();
        reg_rd(ADDR_LRS, 8'h00, 1'b1);
        // several levels compete; source enable and priority code decide
        reg_wr(ADDR_MASK, 8'hFF);
        for (int i = 0; i < 8; i++)
        begin
            reg_wr(ADDR_PRIO, prio_tab[i]);
            @(posedge i_clock);
            i_src_en <= en_tab[i];
            i_src_pend <= 16'h0451;
            take(lvl_tab[i], exp_vec({3'h0, lvl_tab[i], 2'h0}), 16);
            @(posedge i_clock);
            i_src_pend <= 16'h0000;
            interrupt_return_instr();
        end
        // fast path on level 3: pointer first, then level, then enable
        @(posedge i_clock);
        i_src_pend <= 16'h0040;
        reg_wr(ADDR_FHP_HIGH, 8'h12);
        reg_wr(ADDR_FHP_LOW, 8'h34);
        reg_wr(ADDR_SYSMODE, 8'h0D);
        reg_wr(ADDR_SYSMODE, 8'h0F);
        take(3'h3, 16'h1234, 6);
        chk_bit(o_fast_status, 1'b1);
        chk_byte(8'(pushes.size()), 8'h00);
        @(posedge i_clock);
        i_pc <= 16'h1240;
        i_flags <= 8'h00;
        i_src_pend <= 16'h0000;
        interrupt_return_instr();
        chk_bit(o_pc_load, 1'b1);
        chk_word(o_pc_value, 16'hABCD);
        chk_bit(o_flags_load, 1'b1);
        chk_byte(o_flags_value, 8'h5A);
        chk_bit(o_fast_status, 1'b0);
        reg_rd(ADDR_SYSMODE, 8'h0F, 1'b1);
        reg_rd(ADDR_FHP_HIGH, 8'h12, 1'b1);
        reg_rd(ADDR_FHP_LOW, 8'h40, 1'b1);
        reg_wr(ADDR_FHP_LOW, 8'h34);
        reg_rd(ADDR_FHP_LOW, 8'h34, 1'b1);
        // global disable still gates the enabled fast level
        @(posedge i_clock);
        i_src_pend <= 16'h0040;
        i_di <= 1'b1;
        @(posedge i_clock);
        i_di <= 1'b0;
        #1;
        chk_bit(o_global_en, 1'b0);
        no_take();
        tally_and_finish();
    end
endmodule
